// ### hw/interrupt_return_seq.sv
// Interrupt return sequencer, freeze protection and emergency trap.
//
// Behaviour
// [RL1] Invalidating return clears all branch cache valid bits; plain return does not.
// [RL2] Return waits for the in-progress access and any multiple-word sequence.
// [RL3] All interrupts and traps are blocked throughout the return sequence; here the emergency trap still aborts a return in progress.
// [RL4] Return copies old status into current status, normally clearing freeze.
// [RL5] Valid, needed, single channel operation restarts one external access.
// [RL6] Fetch at program counter 1 as a branch, then move into decode.
// [RL7] Fetch at program counter 0 as a branch; first to execute, second decode.
// [RL8] Valid, needed, multiple channel operation restarts the multiple-word sequence.
// [RL9] Finally enable interrupts per restored status and resume execution.
// [RL10] Unaltered sequential saved counters make the second fetch sequential.
// [RL11] Freeze holds program counters, channel registers and ALU status.
// [RL12] Frozen loads or stores that set the byte pointer leave it unchanged.
// [RL13] Extended arithmetic does not update carry while frozen.
// [RL14] Divide steps do not update the divide flag while frozen.
// [RL15] The emergency input always traps; no mask or disable suppresses it.
// [RL16] Emergency trap does not wait for access; channel registers keep it.
// [RL17] Emergency trap skips vector fetch, sets ROM enable, fetches ROM 16.
// [RL18] Handler software loads both counters and old status before return.
// [RL19] Handler software sets channel registers to restart pending operations.
// [RL20] Handler software avoids multiple-word transfers while frozen.
// [RL21] A handler that saves no state keeps interrupts disabled.
// [RL22] Taking a trap copies current status to old status and sets freeze.
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_return_defs.svh"
module interrupt_return_seq (
   // Clock, reset and clock enable.
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   // Return instructions from decode, one-cycle pulses.
   input  wire logic        ret_plain,
   input  wire logic        ret_inval,
   // Ordinary trap taken by the priority logic, one-cycle pulse.
   input  wire logic        trap_take,
   // Emergency trap pin, asynchronous, active high.
   input  wire logic        warn_pin,
   // Memory channel state and handshakes.
   input  wire logic        chan_busy,
   input  wire logic        chan_multi_busy,
   input  wire logic        chan_ack,
   input  wire logic        fetch_ack,
   // Pipeline updates of frozen state.
   input  wire logic        pc_upd,
   input  wire logic [31:0] pc_next,
   input  wire logic        chan_upd,
   input  wire logic [31:0] cha_in,
   input  wire logic [31:0] chd_in,
   input  wire logic [31:0] chc_in,
   input  wire logic        carry_upd,
   input  wire logic        carry_in,
   input  wire logic        div_upd,
   input  wire logic        div_in,
   input  wire logic        sb_upd,
   input  wire logic [1:0]  bp_in,
   // Special register writes from software.
   input  wire logic        sw_wr,
   input  wire logic [2:0]  sw_sel,
   input  wire logic [31:0] sw_data,
   // Register contents.
   output var  logic [31:0] cps,
   output var  logic [31:0] ops,
   output var  logic [31:0] pc0,
   output var  logic [31:0] pc1,
   output var  logic [31:0] pc2,
   output var  logic [31:0] cha,
   output var  logic [31:0] chd,
   output var  logic [31:0] chc,
   output var  logic        carry,
   output var  logic        divf,
   output var  logic [1:0]  byte_ptr,
   // Sequencer actions.
   output var  logic        btc_inv,
   output var  logic        fetch_req,
   output var  logic        fetch_branch,
   output var  logic [31:0] fetch_addr,
   output var  logic        chan_start,
   output var  logic        chan_multi,
   output var  logic        to_decode,
   output var  logic        to_execute,
   output var  logic        irq_block,
   output var  logic        irq_enable,
   output var  logic        ret_done,
   output var  logic        warn_taken
);
   interrupt_return_pkg::interrupt_return_state_t st_ff;
   interrupt_return_pkg::interrupt_return_state_t nxt_st;
   logic                  rst_sync_n;
   logic                  warn_sync;

   // Reset is released through two flops; the pin is synchronised likewise.
   sync2 u_rst_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (1'b1),
      .q    (rst_sync_n)
   );
   sync2 u_warn_sync (
      .clk  (clk),
      .rstn (rst_sync_n),
      .d    (warn_pin),
      .q    (warn_sync)
   );

   // Decodes the channel control word: 1 single restart, 2 multiple restart.
   function automatic logic [1:0] chan_kind(input logic [31:0] c);
      logic live;
      live = c[`INTERRUPT_RETURN_CH_CV] & ~c[`INTERRUPT_RETURN_CH_NN];
      chan_kind = {live & c[`INTERRUPT_RETURN_CH_ML], live & ~c[`INTERRUPT_RETURN_CH_ML]};
   endfunction

   // Interrupt enable from a status word; used while idle and at the final enable step.
   function automatic logic irq_allowed(input logic [31:0] s);
      irq_allowed = ~s[`INTERRUPT_RETURN_ST_DA] & ~s[`INTERRUPT_RETURN_ST_DI]
                  & (s[`INTERRUPT_RETURN_ST_IM_HI:`INTERRUPT_RETURN_ST_IM_LO] != 2'h0);
   endfunction

   // Next-state logic for the whole block.
   always_comb begin
      logic frozen;
      logic warn_edge;
      frozen    = st_ff.cps[`INTERRUPT_RETURN_ST_FZ];
      warn_edge = warn_sync & ~st_ff.warn_prev;
      nxt_st    = st_ff;
      nxt_st.warn_prev  = warn_sync;
      nxt_st.btc_inv    = 1'b0;
      nxt_st.fetch_req  = 1'b0;
      nxt_st.chan_start = 1'b0;
      nxt_st.chan_multi = 1'b0;
      nxt_st.to_decode  = 1'b0;
      nxt_st.to_execute = 1'b0;
      nxt_st.ret_done   = 1'b0;
      nxt_st.warn_taken = 1'b0;

      // Pipeline updates of frozen state apply only while freeze is clear.
      if (pc_upd && !frozen) begin                         // [RL11]
         nxt_st.pc2 = st_ff.pc1;
         nxt_st.pc1 = st_ff.pc0;
         nxt_st.pc0 = pc_next;
      end
      if (chan_upd && !frozen) begin                       // [RL11]
         nxt_st.cha = cha_in;
         nxt_st.chd = chd_in;
         nxt_st.chc = chc_in;
      end
      if (carry_upd && !frozen) begin                      // [RL13]
         nxt_st.carry = carry_in;
      end
      if (div_upd && !frozen) begin                        // [RL14]
         nxt_st.divf = div_in;
      end
      if (sb_upd && !frozen) begin                         // [RL12]
         nxt_st.byte_ptr = bp_in;
      end

      // Explicit writes set up the return; counter writes break sequence.
      if (sw_wr) begin
         case (sw_sel)
            `INTERRUPT_RETURN_SEL_OPS: nxt_st.ops = sw_data;
            `INTERRUPT_RETURN_SEL_PC0: begin
               nxt_st.pc0    = sw_data;
               nxt_st.seq_ok = 1'b0;                       // [RL10]
            end
            `INTERRUPT_RETURN_SEL_PC1: begin
               nxt_st.pc1    = sw_data;
               nxt_st.seq_ok = 1'b0;                       // [RL10]
            end
            `INTERRUPT_RETURN_SEL_CHA: nxt_st.cha = sw_data;
            `INTERRUPT_RETURN_SEL_CHD: nxt_st.chd = sw_data;
            `INTERRUPT_RETURN_SEL_CHC: nxt_st.chc = sw_data;
            `INTERRUPT_RETURN_SEL_CPS: nxt_st.cps = sw_data;
            default:       nxt_st.ops = st_ff.ops;
         endcase
      end

      // Return sequence; interrupts stay blocked until the last step.
      case (st_ff.state)
         interrupt_return_pkg::S_IDLE: begin
            nxt_st.irq_enable = irq_allowed(st_ff.cps);
            if (ret_plain || ret_inval) begin
               nxt_st.inv_pend   = ret_inval;
               nxt_st.irq_block  = 1'b1;                   // [RL3]
               nxt_st.irq_enable = 1'b0;                   // [RL3]
               nxt_st.state      = interrupt_return_pkg::S_DRAIN;
            end else if (trap_take) begin
               // Note whether the counters held sequential addresses when the trap hit.
               nxt_st.ops    = st_ff.cps;                  // [RL22]
               nxt_st.cps[`INTERRUPT_RETURN_ST_FZ] = 1'b1;             // [RL22]
               nxt_st.seq_ok = (st_ff.pc0 == st_ff.pc1 + `INTERRUPT_RETURN_PC_STEP);
            end
         end
         interrupt_return_pkg::S_DRAIN: begin
            nxt_st.irq_enable = 1'b0;
            if (!chan_busy && !chan_multi_busy) begin      // [RL2]
               nxt_st.state = interrupt_return_pkg::S_INVAL;
            end
         end
         interrupt_return_pkg::S_INVAL: begin
            nxt_st.btc_inv = st_ff.inv_pend;               // [RL1]
            nxt_st.state   = interrupt_return_pkg::S_RESTORE;
         end
         interrupt_return_pkg::S_RESTORE: begin
            // Fields owned by hardware would override here; none in this block.
            nxt_st.cps = st_ff.ops;                        // [RL4]
            if (chan_kind(st_ff.chc) == 2'h1) begin        // [RL5]
               nxt_st.chan_start = 1'b1;
               nxt_st.state      = interrupt_return_pkg::S_SINGLE;
            end else begin
               nxt_st.fetch_req    = 1'b1;                 // [RL6]
               nxt_st.fetch_branch = 1'b1;
               nxt_st.fetch_addr   = st_ff.pc1;
               nxt_st.state        = interrupt_return_pkg::S_FETCH1;
            end
         end
         interrupt_return_pkg::S_SINGLE: begin
            if (chan_ack) begin
               nxt_st.fetch_req    = 1'b1;                 // [RL6]
               nxt_st.fetch_branch = 1'b1;
               nxt_st.fetch_addr   = st_ff.pc1;
               nxt_st.state        = interrupt_return_pkg::S_FETCH1;
            end
         end
         interrupt_return_pkg::S_FETCH1: begin
            if (fetch_ack) begin
               nxt_st.to_decode    = 1'b1;                 // [RL6]
               nxt_st.fetch_req    = 1'b1;                 // [RL7]
               nxt_st.fetch_branch = ~st_ff.seq_ok;        // [RL10]
               nxt_st.fetch_addr   = st_ff.pc0;
               nxt_st.state        = interrupt_return_pkg::S_FETCH0;
            end
         end
         interrupt_return_pkg::S_FETCH0: begin
            if (fetch_ack) begin
               nxt_st.to_decode  = 1'b1;                   // [RL7]
               nxt_st.to_execute = 1'b1;                   // [RL7]
               if (chan_kind(st_ff.chc) == 2'h2) begin     // [RL8]
                  nxt_st.chan_start = 1'b1;
                  nxt_st.chan_multi = 1'b1;
                  nxt_st.state      = interrupt_return_pkg::S_MULTI;
               end else begin
                  nxt_st.state = interrupt_return_pkg::S_ENABLE;
               end
            end
         end
         interrupt_return_pkg::S_MULTI: begin
            if (chan_ack) begin
               nxt_st.state = interrupt_return_pkg::S_ENABLE;
            end
         end
         interrupt_return_pkg::S_ENABLE: begin
            nxt_st.irq_block  = 1'b0;                      // [RL9]
            nxt_st.irq_enable = irq_allowed(st_ff.cps);    // [RL9]
            nxt_st.ret_done   = 1'b1;
            nxt_st.seq_ok     = 1'b0;
            nxt_st.state      = interrupt_return_pkg::S_IDLE;
         end
         default: begin
            nxt_st.state = interrupt_return_pkg::S_IDLE;
         end
      endcase

      // The emergency trap beats everything, even a return in progress.
      // Channel registers are left alone so the lost access stays visible.
      if (warn_edge) begin                                 // [RL15]
         nxt_st.ops               = st_ff.cps;             // [RL22]
         nxt_st.cps               = st_ff.cps;
         nxt_st.cps[`INTERRUPT_RETURN_ST_FZ]  = 1'b1;
         nxt_st.cps[`INTERRUPT_RETURN_ST_RE]  = 1'b1;                  // [RL17]
         nxt_st.fetch_req         = 1'b1;                  // [RL17]
         nxt_st.fetch_branch      = 1'b1;
         nxt_st.fetch_addr        = `INTERRUPT_RETURN_ROM_ENTRY;       // [RL17]
         nxt_st.chan_start        = 1'b0;                  // [RL16]
         nxt_st.chan_multi        = 1'b0;
         nxt_st.btc_inv           = 1'b0;
         nxt_st.to_decode         = 1'b0;
         nxt_st.to_execute        = 1'b0;
         nxt_st.ret_done          = 1'b0;
         nxt_st.irq_block         = 1'b0;
         nxt_st.irq_enable        = 1'b0;
         nxt_st.seq_ok            = 1'b0;
         nxt_st.warn_taken        = 1'b1;
         nxt_st.state             = interrupt_return_pkg::S_IDLE;
      end
   end

   // One register for all state but the two synchronisers; clock enable freezes that register.
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_ff              <= '0;
         st_ff.state        <= interrupt_return_pkg::S_IDLE;
         st_ff.cps          <= `INTERRUPT_RETURN_RESET_WORD;
         st_ff.ops          <= `INTERRUPT_RETURN_RESET_WORD;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // Outputs are taken straight from the state register.
   assign cps          = st_ff.cps;
   assign ops          = st_ff.ops;
   assign pc0          = st_ff.pc0;
   assign pc1          = st_ff.pc1;
   assign pc2          = st_ff.pc2;
   assign cha          = st_ff.cha;
   assign chd          = st_ff.chd;
   assign chc          = st_ff.chc;
   assign carry        = st_ff.carry;
   assign divf         = st_ff.divf;
   assign byte_ptr     = st_ff.byte_ptr;
   assign btc_inv      = st_ff.btc_inv;
   assign fetch_req    = st_ff.fetch_req;
   assign fetch_branch = st_ff.fetch_branch;
   assign fetch_addr   = st_ff.fetch_addr;
   assign chan_start   = st_ff.chan_start;
   assign chan_multi   = st_ff.chan_multi;
   assign to_decode    = st_ff.to_decode;
   assign to_execute   = st_ff.to_execute;
   assign irq_block    = st_ff.irq_block;
   assign irq_enable   = st_ff.irq_enable;
   assign ret_done     = st_ff.ret_done;
   assign warn_taken   = st_ff.warn_taken;
endmodule // interrupt_return_seq
`default_nettype wire

// ### hw/interrupt_return_defs.svh
// Constants for the interrupt return and emergency trap sequencer.
`ifndef INTERRUPT_RETURN_DEFS_SVH
`define INTERRUPT_RETURN_DEFS_SVH
`define INTERRUPT_RETURN_W          32
`define INTERRUPT_RETURN_ST_FZ      10
`define INTERRUPT_RETURN_ST_RE      4
`define INTERRUPT_RETURN_ST_DA      0
`define INTERRUPT_RETURN_ST_DI      1
`define INTERRUPT_RETURN_ST_IM_LO   2
`define INTERRUPT_RETURN_ST_IM_HI   3
`define INTERRUPT_RETURN_CH_CV      15
`define INTERRUPT_RETURN_CH_ML      17
`define INTERRUPT_RETURN_CH_NN      31
`define INTERRUPT_RETURN_ROM_ENTRY  32'h0000_0010
`define INTERRUPT_RETURN_PC_STEP    32'h0000_0004
`define INTERRUPT_RETURN_RESET_WORD 32'h0000_0000
`define INTERRUPT_RETURN_SEL_OPS    3'h1
`define INTERRUPT_RETURN_SEL_PC0    3'h2
`define INTERRUPT_RETURN_SEL_PC1    3'h3
`define INTERRUPT_RETURN_SEL_CHA    3'h4
`define INTERRUPT_RETURN_SEL_CHD    3'h5
`define INTERRUPT_RETURN_SEL_CHC    3'h6
`define INTERRUPT_RETURN_SEL_CPS    3'h7
`endif

// ### hw/interrupt_return_pkg.sv
// Types for the interrupt return and emergency trap sequencer.
`default_nettype none
package interrupt_return_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_DRAIN, S_INVAL, S_RESTORE, S_SINGLE,
      S_FETCH1, S_FETCH0, S_MULTI, S_ENABLE
   } seq_state_t;

   typedef struct packed {
      seq_state_t  state;
      logic        inv_pend;
      logic        seq_ok;
      logic [31:0] cps;
      logic [31:0] ops;
      logic [31:0] pc0;
      logic [31:0] pc1;
      logic [31:0] pc2;
      logic [31:0] cha;
      logic [31:0] chd;
      logic [31:0] chc;
      logic        carry;
      logic        divf;
      logic [1:0]  byte_ptr;
      logic        btc_inv;
      logic        fetch_req;
      logic        fetch_branch;
      logic [31:0] fetch_addr;
      logic        chan_start;
      logic        chan_multi;
      logic        to_decode;
      logic        to_execute;
      logic        irq_block;
      logic        irq_enable;
      logic        ret_done;
      logic        warn_taken;
      logic        warn_prev;
   } interrupt_return_state_t;
endpackage
`default_nettype wire

// ### hw/sync2.sv
// Two-flop synchroniser for a single level.
`timescale 1ns/1ps
`default_nettype none
module sync2 (
   // Clock and asynchronous reset.
   input  wire logic clk,
   input  wire logic rstn,
   // Level in and synchronised level out.
   input  wire logic d,
   output var  logic q
);
   logic meta_ff;

   // The first flop is read only by the second flop.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= 1'b0;
         q       <= 1'b0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule // sync2
`default_nettype wire

// ### sim/interrupt_return_seq_monitor.sv
// Port checker for the interrupt return and emergency trap sequencer.
`timescale 1ns/1ps
`default_nettype none
module interrupt_return_seq_monitor (
   // Clock, reset and requests.
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        ce,
   input wire logic        ret_plain,
   input wire logic        ret_inval,
   input wire logic        trap_take,
   input wire logic        warn_pin,
   input wire logic        chan_busy,
   input wire logic        chan_multi_busy,
   input wire logic        sw_wr,
   // Register contents.
   input wire logic [31:0] cps,
   input wire logic [31:0] ops,
   input wire logic [31:0] pc0,
   input wire logic [31:0] pc1,
   input wire logic [31:0] cha,
   input wire logic [31:0] chc,
   input wire logic        carry,
   input wire logic        divf,
   input wire logic [1:0]  byte_ptr,
   // Sequencer actions.
   input wire logic        btc_inv,
   input wire logic        fetch_req,
   input wire logic        fetch_branch,
   input wire logic [31:0] fetch_addr,
   input wire logic        chan_start,
   input wire logic        chan_multi,
   input wire logic        to_decode,
   input wire logic        irq_block,
   input wire logic        irq_enable,
   input wire logic        ret_done,
   input wire logic        warn_taken
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic plain_ff;

   // Remembers the kind of return last taken, so a plain one never flushes.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         plain_ff <= 1'b0;
      else if (ce && !irq_block && (ret_plain || ret_inval))
         plain_ff <= ret_plain;
   end

   AST_PLAIN_KEEPS_CACHE:
      assert property (plain_ff |-> !btc_inv) else $error("plain flush");
   AST_DRAIN_FIRST:
      assert property (irq_block && $past(chan_busy || chan_multi_busy)
         |-> !btc_inv && !fetch_req) else $error("no drain");
   AST_BLOCK_NO_ENABLE:
      assert property (irq_block |-> !irq_enable) else $error("not blocked");
   AST_RESTORE_COPY:
      assert property (irq_block && fetch_req && !to_decode |-> cps == ops)
         else $error("status not restored");
   AST_FIRST_FETCH:
      assert property (irq_block && fetch_req && !to_decode
         |-> fetch_branch && fetch_addr == pc1) else $error("bad fetch 1");
   AST_SECOND_FETCH:
      assert property (irq_block && fetch_req && to_decode
         |-> fetch_addr == pc0) else $error("bad fetch 2");
   AST_SINGLE_START:
      assert property (chan_start && !chan_multi
         |-> irq_block && chc[15] && !chc[31] && !chc[17])
         else $error("bad single restart");
   AST_MULTI_START:
      assert property (chan_multi |-> chan_start && chc[15] && !chc[31]
         && chc[17]) else $error("bad multi restart");
   AST_ENABLE_STATUS:
      assert property (ret_done |-> !irq_block && irq_enable == (!cps[0]
         && !cps[1] && cps[3:2] != 2'h0)) else $error("bad enable");
   AST_FREEZE_HOLD:
      assert property (cps[10] && !sw_wr |=> $stable(pc0) && $stable(pc1)
         && $stable(cha) && $stable(chc)) else $error("frozen reg moved");
   AST_FREEZE_ALU:
      assert property (cps[10] |=> $stable(carry) && $stable(divf)
         && $stable(byte_ptr)) else $error("frozen alu moved");
   AST_WARN_RESPONSE:
      assert property (ce && $rose(warn_pin) |-> ##[1:6] warn_taken)
         else $error("warn missed");
   AST_WARN_ENTRY:
      assert property (warn_taken |-> fetch_req && fetch_addr == 32'h10
         && cps[4] && $stable(chc)) else $error("bad warn entry");
   AST_TRAP_SAVES:
      assert property (ce && trap_take && !irq_block && !ret_plain
         && !ret_inval |=> ops == $past(cps) && cps[10])
         else $error("trap status");
endmodule // interrupt_return_seq_monitor

bind interrupt_return_seq interrupt_return_seq_monitor mon (.*);
`default_nettype wire

// ### sim/chan_model.sv
// Memory channel model answering fetches and channel restarts.
`timescale 1ns/1ps
`default_nettype none
module chan_model (
   // Clock, reset and answer delay in cycles.
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [3:0] wait_n,
   // Requests and their one-cycle answers.
   input  wire logic       fetch_req,
   input  wire logic       chan_start,
   output var  logic       fetch_ack,
   output var  logic       chan_ack
);
   logic [3:0] f_cnt, c_cnt;

   // A slow memory is modelled by idling wait_n cycles before answering.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {f_cnt, c_cnt, fetch_ack, chan_ack} <= '0;
      end else begin
         fetch_ack <= fetch_req ? (wait_n == 4'h0) : (f_cnt == 4'h1);
         chan_ack <= chan_start ? (wait_n == 4'h0) : (c_cnt == 4'h1);
         f_cnt <= fetch_req ? wait_n : f_cnt - {3'h0, f_cnt != 4'h0};
         c_cnt <= chan_start ? wait_n : c_cnt - {3'h0, c_cnt != 4'h0};
      end
   end
endmodule // chan_model
`default_nettype wire

// ### sim/tb_interrupt_return_and_warn_trap.sv
// Self-checking bench for the interrupt return and emergency trap block.
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_return_and_warn_trap;
   logic        clk, rstn, ce, ret_plain, ret_inval, trap_take, warn_pin;
   logic        chan_busy, chan_multi_busy, chan_ack, fetch_ack, pc_upd;
   logic        chan_upd, carry_upd, carry_in, div_upd, div_in, sb_upd;
   logic        sw_wr, carry, divf, btc_inv, fetch_req, fetch_branch;
   logic        chan_start, chan_multi, to_decode, to_execute, irq_block;
   logic        irq_enable, ret_done, warn_taken, multi_seen;
   logic [1:0]  bp_in, byte_ptr;
   logic [2:0]  sw_sel;
   logic [3:0]  wait_n;
   logic [31:0] pc_next, cha_in, chd_in, chc_in, sw_data, fetch_addr;
   logic [31:0] cps, ops, pc0, pc1, pc2, cha, chd, chc;
   logic [31:0] fa [2];
   logic        fb [2];
   int          mismatches, n_compared, n_inv, n_fetch, st_at, first_act;
   int          done_at, n_dec, n_exe;

   interrupt_return_seq dut (.*);
   chan_model partner (.*);

   // Free-running clock at 25 MHz.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk_w(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_b(input string nm, input logic e, g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %b seen %b", nm, e, g);
      end
   endtask

   // Special register write; it ends just after the writing edge.
   task automatic wr(input logic [2:0] sel, input logic [31:0] d);
      @(posedge clk);
      {sw_wr, sw_sel, sw_data} <= {1'b1, sel, d};
      @(posedge clk);
      sw_wr <= 1'b0;
      #1;
   endtask

   // Every pipeline update at once, with values taken from v.
   task automatic pipe(input logic [31:0] v);
      @(posedge clk);
      {pc_upd, chan_upd, carry_upd, div_upd, sb_upd} <= 5'h1f;
      {pc_next, cha_in, chd_in, chc_in} <= {v, v, v, v};
      {carry_in, div_in, bp_in} <= {v[2], v[2], v[3:2]};
      @(posedge clk);
      {pc_upd, chan_upd, carry_upd, div_upd, sb_upd} <= 5'h0;
      #1;
   endtask

   // Ordinary trap, raised only while no unsaved handler runs.
   task automatic trap_go();
      @(posedge clk);
      trap_take <= 1'b1;
      @(posedge clk);
      trap_take <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   // Issues one return and logs the sequencer's actions until it ends.
   task automatic do_ret(input logic inv, input int busy_n);
      @(posedge clk);
      {ret_plain, ret_inval} <= {~inv, inv};
      @(posedge clk);
      {ret_plain, ret_inval} <= 2'h0;
      {n_inv, n_fetch, done_at, n_dec, n_exe} = '0;
      {st_at, first_act} = '1;
      multi_seen = 1'b0;
      for (int i = 1; i < 80 && done_at == 0; i++) begin
         @(posedge clk);
         if (i == busy_n) chan_busy <= 1'b0;
         #1;
         if (i == 1) chk_b("return blocks", 1'b1, irq_block);
         if (btc_inv) n_inv++;
         if (first_act < 0 && (btc_inv || fetch_req || chan_start))
            first_act = i;
         if (chan_start) {st_at, multi_seen} = {n_fetch, chan_multi};
         if (fetch_req && n_fetch < 2) begin
            {fa[n_fetch], fb[n_fetch]} = {fetch_addr, fetch_branch};
            n_fetch++;
         end
         if (ret_done) done_at = i;
         if (to_decode) n_dec++;
         if (to_execute) n_exe = n_dec;
      end
      chk_b("return done", 1'b1, done_at != 0);
      chk_w("decode count", 32'h2, n_dec);
      chk_w("execute point", 32'h2, n_exe);
   endtask

   task automatic s_trap_freeze();
      wr(3'h7, 32'h0000_000c);
      pipe(32'h0000_0100);
      pipe(32'h0000_0104);
      trap_go();
      chk_w("old status", 32'h0000_000c, ops);
      chk_w("status", 32'h0000_040c, cps);
      pipe(32'h0000_0200);
      chk_w("pc0", 32'h0000_0104, pc0);
      chk_w("pc1", 32'h0000_0100, pc1);
      chk_w("channel data", 32'h0000_0104, chd);
      chk_w("channel address", 32'h0000_0104, cha);
      chk_w("pc2", 32'h0, pc2);
      chk_w("byte pointer", 32'h1, byte_ptr);
      chk_b("carry", 1'b1, carry);
      chk_b("divide flag", 1'b1, divf);
   endtask

   // Plain return, single access restart, untouched sequential counters.
   task automatic s_plain_return();
      wr(3'h6, 32'h0000_8000);
      wr(3'h1, 32'h0000_000c);
      do_ret(1'b0, 0);
      chk_w("flush count", 32'h0, n_inv);
      chk_w("restart point", 32'h0, st_at);
      chk_b("restart multi", 1'b0, multi_seen);
      chk_w("fetch 1 address", 32'h0000_0100, fa[0]);
      chk_b("fetch 1 branch", 1'b1, fb[0]);
      chk_w("fetch 2 address", 32'h0000_0104, fa[1]);
      chk_b("fetch 2 branch", 1'b0, fb[1]);
      chk_w("restored status", 32'h0000_000c, cps);
      chk_b("irq enable", 1'b1, irq_enable);
   endtask

   // Flushing return behind a busy channel, slow memory, multi restart.
   task automatic s_inval_multi();
      trap_go();
      wr(3'h2, 32'h0000_0300);
      wr(3'h6, 32'h0002_8000);
      wr(3'h1, 32'h0000_0001);
      @(posedge clk);
      {wait_n, chan_busy} <= {4'h3, 1'b1};
      do_ret(1'b1, 5);
      chk_w("flush count", 32'h1, n_inv);
      chk_b("drained first", 1'b1, first_act > 5);
      chk_w("restart point", 32'h2, st_at);
      chk_b("restart multi", 1'b1, multi_seen);
      chk_w("fetch 2 address", 32'h0000_0300, fa[1]);
      chk_b("fetch 2 branch", 1'b1, fb[1]);
      chk_b("irq enable", 1'b0, irq_enable);
   endtask

   // Emergency input while everything is disabled and an access hangs.
   task automatic s_warn();
      int n;
      @(posedge clk);
      {chan_busy, warn_pin} <= 2'h3;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (!warn_taken && n < 8);
      chk_b("warn taken", 1'b1, warn_taken);
      chk_w("warn fetch", 32'h0000_0010, fetch_addr);
      chk_w("warn status", 32'h0000_0411, cps);
      chk_w("warn channel", 32'h0002_8000, chc);
      @(posedge clk);
      {chan_busy, warn_pin} <= 2'h0;
   endtask

   // Whole run is under a hundred cycles of the 2500 allowed here, so this only fires on a hang.
   initial begin
      #100000;
      mismatches++;
      finish_test();
   end

   // Main sequence: reset, then the scenarios in order.
   initial begin
      {ret_plain, ret_inval, trap_take, warn_pin, chan_busy} = '0;
      {chan_multi_busy, pc_upd, chan_upd, carry_upd, carry_in} = '0;
      {div_upd, div_in, sb_upd, sw_wr, rstn, ce} = 6'h1;
      {bp_in, sw_sel, wait_n, pc_next, cha_in, chd_in, chc_in, sw_data} = '0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      s_trap_freeze();
      s_plain_return();
      s_inval_multi();
      s_warn();
      finish_test();
   end
endmodule // tb_interrupt_return_and_warn_trap
`default_nettype wire
